/* hw/acmp_ctrl.sv */
// control and status logic around the on-chip analog comparator
// Contract
// [RULE_01] output bit high when selected positive input exceeds selected negative
// [RULE_02] raw result synchronised, output bit lags one to two clocks
// [RULE_03] disable bit 7 powers comparator off, writable any time
// [RULE_04] bandgap select bit 6 feeds bandgap to positive input, else pin
// [RULE_05] flag bit 4 set on output event matching selected mode
// [RULE_06] interrupt requested when flag, enable, global enable set; vector clears flag
// [RULE_07] writing one clears flag, zero leaves it
// [RULE_08] enable bit 3 gates comparator interrupt
// [RULE_09] capture routing bit 2 connects output to timer capture
// [RULE_10] mode field: toggle, reserved, falling, rising
// [RULE_11] software disables interrupt before changing mode or disable bit
// [RULE_12] mux borrow set and converter off: channel select picks negative pin
// [RULE_13] mux borrow clear or converter on: dedicated negative pin used
// [RULE_14] buffer-off bits disable pin buffer and force pin read zero
// [RULE_15] software keeps converter power reduction zero when mux is borrowed
// [RULE_16] converter enable bit decides negative input selection
// [RULE_17] events found by comparing synced output with previous value
// [RULE_18] writable bits reset to zero, output bit follows synced state
`timescale 1ns/1ns
`include "acmp_regs.svh"
module acmp_ctrl
    import acmp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // analog front end
    input wire logic cmp_raw_in,
    output logic comparator_power_on_out,
    output logic bandgap_select_out,
    output logic negative_use_mux_out,
    output logic [2:0] channel_select_out,
    // pins
    input wire logic positive_input_pin_in,
    input wire logic negative_input_pin_in,
    output logic positive_pin_buffer_en_out,
    output logic negative_pin_buffer_en_out,
    output logic positive_pin_read_out,
    output logic negative_pin_read_out,
    // timer and interrupts
    output logic capture_trigger_out,
    input wire logic vector_ack_in,
    output logic cmp_irq_req_out,
    output logic irq_out
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] csr_q;
    logic [7:0] conv_b_q;
    logic [7:0] didr_q;
    logic [7:0] conv_a_q;
    logic [7:0] mux_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic global_ie_q;
    logic cmp_sync;
    logic cmp_prev_q;
    logic cmp_event;
    logic capt_prev_q;
    logic pos_pin_m_q;
    logic pos_pin_q;
    logic neg_pin_m_q;
    logic neg_pin_q;
    logic [7:0] rdata_d;
    logic wr_csr;

    function automatic logic hit(input logic [3:0] addr, input logic [3:0] target);
        hit = (addr == target);
    endfunction : hit

    assign wr_csr = reg_wr_in && hit(reg_addr_in, `ACMP_ADDR_CSR);

    // ----------------------------------------
    // comparator result path
    // ----------------------------------------
    // the analog side compares the selected inputs; raw result is asynchronous
    acmp_sync u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(cmp_raw_in),
        .sync_out(cmp_sync)
    ); // [RULE_01] [RULE_02]

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmp_prev_q <= 1'b0;
        end else begin
            cmp_prev_q <= cmp_sync; // [RULE_17]
        end
    end

    // reserved mode raises nothing
    always_comb begin
        unique case (acmp_mode_t'(csr_q[`ACMP_CSR_MODE_HI:`ACMP_CSR_MODE_LO]))
            ACMP_MODE_TOGGLE: cmp_event = cmp_sync ^ cmp_prev_q; // [RULE_10] [RULE_17]
            ACMP_MODE_RSVD: cmp_event = 1'b0;
            ACMP_MODE_FALL: cmp_event = cmp_prev_q & ~cmp_sync;
            ACMP_MODE_RISE: cmp_event = cmp_sync & ~cmp_prev_q;
        endcase
    end

    // ----------------------------------------
    // control register writes
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            csr_q <= `ACMP_RESET_BYTE; // [RULE_18]
        end else begin
            // set wins over a same-cycle clear or vector acknowledge
            if (cmp_event) begin
                csr_q[`ACMP_CSR_FLAG] <= 1'b1; // [RULE_05]
            end else if ((wr_csr && reg_wdata_in[`ACMP_CSR_FLAG]) || vector_ack_in) begin
                csr_q[`ACMP_CSR_FLAG] <= 1'b0; // [RULE_06] [RULE_07]
            end
            if (wr_csr) begin
                csr_q[`ACMP_CSR_DISABLE] <= reg_wdata_in[`ACMP_CSR_DISABLE]; // [RULE_03]
                csr_q[`ACMP_CSR_BANDGAP] <= reg_wdata_in[`ACMP_CSR_BANDGAP]; // [RULE_04]
                csr_q[`ACMP_CSR_IE] <= reg_wdata_in[`ACMP_CSR_IE]; // [RULE_08]
                csr_q[`ACMP_CSR_CAPT] <= reg_wdata_in[`ACMP_CSR_CAPT]; // [RULE_09]
                csr_q[`ACMP_CSR_MODE_HI] <= reg_wdata_in[`ACMP_CSR_MODE_HI]; // [RULE_10]
                csr_q[`ACMP_CSR_MODE_LO] <= reg_wdata_in[`ACMP_CSR_MODE_LO];
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            conv_b_q <= `ACMP_RESET_BYTE;
            didr_q <= `ACMP_RESET_BYTE;
            conv_a_q <= `ACMP_RESET_BYTE;
            mux_q <= `ACMP_RESET_BYTE;
            irq_mask_q <= 2'h0;
            global_ie_q <= 1'b0;
        end else if (reg_wr_in) begin
            if (hit(reg_addr_in, `ACMP_ADDR_CONV_B)) begin
                conv_b_q <= reg_wdata_in;
            end
            if (hit(reg_addr_in, `ACMP_ADDR_DIDR)) begin
                didr_q <= reg_wdata_in;
            end
            if (hit(reg_addr_in, `ACMP_ADDR_CONV_A)) begin
                conv_a_q <= reg_wdata_in;
            end
            if (hit(reg_addr_in, `ACMP_ADDR_MUX)) begin
                mux_q <= reg_wdata_in;
            end
            if (hit(reg_addr_in, `ACMP_ADDR_IRQ_MASK)) begin
                irq_mask_q <= reg_wdata_in[1:0];
            end
            if (hit(reg_addr_in, `ACMP_ADDR_GLOBAL)) begin
                global_ie_q <= reg_wdata_in[`ACMP_GLOBAL_IE];
            end
        end
    end

    // ----------------------------------------
    // analog steering
    // ----------------------------------------
    assign comparator_power_on_out = ~csr_q[`ACMP_CSR_DISABLE]; // [RULE_03]
    assign bandgap_select_out = csr_q[`ACMP_CSR_BANDGAP]; // [RULE_04]
    // converter running owns the mux, so the dedicated pin is used then
    assign negative_use_mux_out = conv_b_q[`ACMP_CONVB_MUXEN]
        & ~conv_a_q[`ACMP_CONVA_EN]; // [RULE_12] [RULE_13] [RULE_16]
    assign channel_select_out = mux_q[2:0]; // [RULE_12]
    assign capture_trigger_out = csr_q[`ACMP_CSR_CAPT] & cmp_sync; // [RULE_09]

    // ----------------------------------------
    // pin input buffers
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pos_pin_m_q <= 1'b0;
            pos_pin_q <= 1'b0;
            neg_pin_m_q <= 1'b0;
            neg_pin_q <= 1'b0;
        end else begin
            pos_pin_m_q <= positive_input_pin_in;
            pos_pin_q <= pos_pin_m_q;
            neg_pin_m_q <= negative_input_pin_in;
            neg_pin_q <= neg_pin_m_q;
        end
    end

    assign positive_pin_buffer_en_out = ~didr_q[`ACMP_DIDR_POS]; // [RULE_14]
    assign negative_pin_buffer_en_out = ~didr_q[`ACMP_DIDR_NEG]; // [RULE_14]
    assign positive_pin_read_out = pos_pin_q & ~didr_q[`ACMP_DIDR_POS]; // [RULE_14]
    assign negative_pin_read_out = neg_pin_q & ~didr_q[`ACMP_DIDR_NEG]; // [RULE_14]

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            capt_prev_q <= 1'b0;
        end else begin
            capt_prev_q <= capture_trigger_out;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_stat_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == `ACMP_IRQ_EVENT && cmp_event)
                    || (i == `ACMP_IRQ_CAPT && capture_trigger_out && !capt_prev_q)) begin
                    irq_stat_q[i] <= 1'b1;
                end else if (reg_wr_in && hit(reg_addr_in, `ACMP_ADDR_IRQ_STAT)
                             && reg_wdata_in[i]) begin
                    irq_stat_q[i] <= 1'b0;
                end
            end
        end
    end

    // rely on software masking enable around mode changes; no glitch filter here
    assign cmp_irq_req_out = csr_q[`ACMP_CSR_FLAG] & csr_q[`ACMP_CSR_IE]
        & global_ie_q; // [RULE_06] [RULE_08] [RULE_11]
    assign irq_out = |(irq_stat_q & irq_mask_q);

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_addr_in)
            `ACMP_ADDR_CSR: begin
                rdata_d = csr_q;
                rdata_d[`ACMP_CSR_OUTPUT] = cmp_sync; // [RULE_02] [RULE_18]
            end
            `ACMP_ADDR_CONV_B: rdata_d = conv_b_q;
            `ACMP_ADDR_DIDR: rdata_d = didr_q;
            `ACMP_ADDR_CONV_A: rdata_d = conv_a_q;
            `ACMP_ADDR_MUX: rdata_d = mux_q;
            `ACMP_ADDR_IRQ_STAT: rdata_d = {6'h00, irq_stat_q};
            `ACMP_ADDR_IRQ_MASK: rdata_d = {6'h00, irq_mask_q};
            `ACMP_ADDR_GLOBAL: rdata_d = {7'h00, global_ie_q};
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rdata_d;
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_rise;
        cmp_sync && !cmp_prev_q;
    endsequence

    property p_sync_lag;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        $rose(cmp_raw_in) ##1 cmp_raw_in[*2] |-> cmp_sync;
    endproperty
    a_sync_lag: assert property (p_sync_lag) else $error("output bit lags too long"); // [RULE_02]

    property p_flag_rise;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (csr_q[1:0] == 2'h3) and s_rise |=> csr_q[`ACMP_CSR_FLAG];
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("rise did not set flag"); // [RULE_05]

    property p_rsvd;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (csr_q[1:0] == 2'h1) |-> !cmp_event;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved mode raised event"); // [RULE_10]

    property p_w1c;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        wr_csr && reg_wdata_in[`ACMP_CSR_FLAG] && !cmp_event |=> !csr_q[`ACMP_CSR_FLAG];
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared by one"); // [RULE_07]

    property p_w0_keep;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        wr_csr && !reg_wdata_in[`ACMP_CSR_FLAG] && !vector_ack_in && csr_q[`ACMP_CSR_FLAG]
        |=> csr_q[`ACMP_CSR_FLAG];
    endproperty
    a_w0_keep: assert property (p_w0_keep) else $error("zero write changed flag"); // [RULE_07]

    property p_vector;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        vector_ack_in && !cmp_event |=> !cmp_irq_req_out;
    endproperty
    a_vector: assert property (p_vector) else $error("vector did not clear flag"); // [RULE_06]

    property p_disable;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        wr_csr |=> comparator_power_on_out == !$past(reg_wdata_in[`ACMP_CSR_DISABLE]);
    endproperty
    a_disable: assert property (p_disable) else $error("disable bit not applied"); // [RULE_03]

    property p_neg_sel;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        conv_a_q[`ACMP_CONVA_EN] |-> !negative_use_mux_out;
    endproperty
    a_neg_sel: assert property (p_neg_sel) else $error("mux used while converter on"); // [RULE_13]

    property p_didr;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        didr_q[`ACMP_DIDR_NEG] |-> !negative_pin_read_out && !negative_pin_buffer_en_out;
    endproperty
    a_didr: assert property (p_didr) else $error("disabled pin not zero"); // [RULE_14]

endmodule : acmp_ctrl

/* hw/acmp_regs.svh */
// register offsets, field positions and reset values of the comparator control block
`ifndef ACMP_REGS_SVH
`define ACMP_REGS_SVH

// ----------------------------------------
// offsets (block-local map)
// ----------------------------------------
`define ACMP_ADDR_CSR 4'h0
`define ACMP_ADDR_CONV_B 4'h1
`define ACMP_ADDR_DIDR 4'h2
`define ACMP_ADDR_CONV_A 4'h3
`define ACMP_ADDR_MUX 4'h4
`define ACMP_ADDR_IRQ_STAT 4'h5
`define ACMP_ADDR_IRQ_MASK 4'h6
`define ACMP_ADDR_GLOBAL 4'h7

// ----------------------------------------
// control/status field positions
// ----------------------------------------
`define ACMP_CSR_DISABLE 7
`define ACMP_CSR_BANDGAP 6
`define ACMP_CSR_OUTPUT 5
`define ACMP_CSR_FLAG 4
`define ACMP_CSR_IE 3
`define ACMP_CSR_CAPT 2
`define ACMP_CSR_MODE_HI 1
`define ACMP_CSR_MODE_LO 0
`define ACMP_CONVB_MUXEN 6
`define ACMP_CONVA_EN 7
`define ACMP_DIDR_NEG 1
`define ACMP_DIDR_POS 0
`define ACMP_GLOBAL_IE 0

// ----------------------------------------
// reset values and interrupt status layout
// ----------------------------------------
`define ACMP_RESET_BYTE 8'h00
`define ACMP_IRQ_EVENT 0
`define ACMP_IRQ_CAPT 1
`define ACMP_SYNC_STAGES 2

`endif

/* hw/acmp_pkg.sv */
// types for the comparator control block
package acmp_pkg;

    typedef enum logic [1:0] {
        ACMP_MODE_TOGGLE = 2'h0,
        ACMP_MODE_RSVD = 2'h1,
        ACMP_MODE_FALL = 2'h2,
        ACMP_MODE_RISE = 2'h3
    } acmp_mode_t;

    typedef enum logic [1:0] {
        ACMP_NEG_PIN,
        ACMP_NEG_MUX
    } acmp_neg_src_t;

endpackage : acmp_pkg

/* hw/acmp_sync.sv */
// two-flop synchroniser for the analog comparator result
`timescale 1ns/1ns
module acmp_sync (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // data
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : acmp_sync

/* dv/acmp_analog_model.sv */
// behavioural analog front end: comparator with its input selection
`timescale 1ns/1ns
module acmp_analog_model #(
    parameter logic [15:0] BANDGAP_MV = 16'h044C
) (
    // selects from the block
    input wire logic power_on_in,
    input wire logic bandgap_select_in,
    input wire logic use_mux_in,
    input wire logic [2:0] channel_in,
    // pin voltages in millivolts
    input wire logic [15:0] pos_mv_in,
    input wire logic [15:0] neg_mv_in,
    input wire logic [15:0] mux_mv_in [8],
    // raw result
    output logic cmp_raw_out
);
    logic [15:0] p_mv;
    logic [15:0] n_mv;
    always_comb begin
        p_mv = bandgap_select_in ? BANDGAP_MV : pos_mv_in;
        n_mv = use_mux_in ? mux_mv_in[channel_in] : neg_mv_in;
        // unpowered comparator parks low, no stale result leaks out
        cmp_raw_out = power_on_in && (p_mv > n_mv);
    end
endmodule : acmp_analog_model

/* dv/acmp_ctrl_bench.sv */
// self-checking bench for the comparator control block
`timescale 1ns/1ns
`include "acmp_regs.svh"
module acmp_ctrl_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ack = 1'b0;
    logic ppin = 1'b0;
    logic npin = 1'b0;
    logic rd_seen = 1'b0;
    logic [15:0] pos_mv = 16'h0000;
    logic [15:0] neg_mv = 16'h01F4;
    logic [15:0] mux_mv [8];
    logic raw, pwr, bg, use_mux, pbuf, nbuf, prd, nrd, capt, req, irq, f;
    logic [1:0] d;
    logic [2:0] chan;
    logic [7:0] rdata;
    logic [7:0] exp_q [$];
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int seed = 32'h0155;

    initial forever #5 clk = ~clk;

    acmp_ctrl u_acmp_ctrl (.sys_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .cmp_raw_in(raw), .comparator_power_on_out(pwr), .bandgap_select_out(bg),
        .negative_use_mux_out(use_mux), .channel_select_out(chan),
        .positive_input_pin_in(ppin), .negative_input_pin_in(npin),
        .positive_pin_buffer_en_out(pbuf), .negative_pin_buffer_en_out(nbuf),
        .positive_pin_read_out(prd), .negative_pin_read_out(nrd),
        .capture_trigger_out(capt), .vector_ack_in(ack), .cmp_irq_req_out(req),
        .irq_out(irq));

    acmp_analog_model u_acmp_analog_model (.power_on_in(pwr), .bandgap_select_in(bg),
        .use_mux_in(use_mux), .channel_in(chan), .pos_mv_in(pos_mv), .neg_mv_in(neg_mv),
        .mux_mv_in(mux_mv), .cmp_raw_out(raw));

    // ----------------------------------------
    // bus tasks and scoreboard
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(v);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    // read data stands only in the cycle after the strobe
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) begin
        if (rd_seen) begin
            chk(rdata, exp_q.pop_front());
        end
    end

    // generous ceiling, the run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        for (int i = 0; i < 8; i++) mux_mv[i] = 16'h0000;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk(8'({pwr, pbuf, nbuf, req, irq}), 8'h1C);
        for (int a = 0; a < 9; a++) rd_reg(4'(a), 8'h00);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            // mode changed only with the interrupt off
            wr_reg(`ACMP_ADDR_CSR, 8'h10 | 8'(m));
            pos_mv <= 16'h03E8;
            repeat (4) @(posedge clk);
            f = (m == 0 || m == 3);
            rd_reg(`ACMP_ADDR_CSR, {3'b001, f, 2'b00, 2'(m)});
            wr_reg(`ACMP_ADDR_CSR, 8'(m));
            rd_reg(`ACMP_ADDR_CSR, {3'b001, f, 2'b00, 2'(m)});
            wr_reg(`ACMP_ADDR_CSR, 8'h10 | 8'(m));
            pos_mv <= 16'h0000;
            repeat (4) @(posedge clk);
            f = (m == 0 || m == 2);
            rd_reg(`ACMP_ADDR_CSR, {3'b000, f, 2'b00, 2'(m)});
        end
        $display("test modes done");
        wr_reg(`ACMP_ADDR_IRQ_STAT, 8'h03);
        wr_reg(`ACMP_ADDR_CSR, 8'h18);
        pos_mv <= 16'h03E8;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(8'({req, irq}), 8'h00);
        wr_reg(`ACMP_ADDR_GLOBAL, 8'h01);
        wr_reg(`ACMP_ADDR_IRQ_MASK, 8'h01);
        @(negedge clk);
        chk(8'({req, irq}), 8'h03);
        rd_reg(`ACMP_ADDR_IRQ_STAT, 8'h01);
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        @(negedge clk);
        chk(8'({req, irq}), 8'h01);
        pos_mv <= 16'h0000;
        wr_reg(`ACMP_ADDR_CSR, 8'h00);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(8'(req), 8'h00);
        wr_reg(`ACMP_ADDR_IRQ_MASK, 8'h00);
        @(negedge clk);
        chk(8'(irq), 8'h00);
        wr_reg(`ACMP_ADDR_IRQ_STAT, 8'h03);
        rd_reg(`ACMP_ADDR_IRQ_STAT, 8'h00);
        $display("test interrupt done");
        // toggle event from the falling input above left the flag set, clear it here
        wr_reg(`ACMP_ADDR_CSR, 8'h51);
        repeat (4) @(posedge clk);
        rd_reg(`ACMP_ADDR_CSR, 8'h61);
        pos_mv <= 16'h03E8;
        wr_reg(`ACMP_ADDR_CSR, 8'h05);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(8'({capt, bg}), 8'h02);
        wr_reg(`ACMP_ADDR_CSR, 8'h01);
        @(negedge clk);
        chk(8'(capt), 8'h00);
        rd_reg(`ACMP_ADDR_IRQ_STAT, 8'h02);
        // converter left off while its mux is borrowed
        wr_reg(`ACMP_ADDR_CONV_B, 8'h40);
        for (int c = 0; c < 8; c++) begin
            mux_mv[c] <= 16'($random(seed)) % 16'h07D0;
            wr_reg(`ACMP_ADDR_MUX, 8'(c));
            repeat (4) @(posedge clk);
            rd_reg(`ACMP_ADDR_CSR, {2'b00, 16'h03E8 > mux_mv[c], 5'h01});
            chk(8'({use_mux, chan}), 8'h08 | 8'(c));
        end
        wr_reg(`ACMP_ADDR_CONV_A, 8'h80);
        repeat (4) @(posedge clk);
        rd_reg(`ACMP_ADDR_CSR, 8'h21);
        chk(8'(use_mux), 8'h00);
        rd_reg(`ACMP_ADDR_CONV_A, 8'h80);
        rd_reg(`ACMP_ADDR_CONV_B, 8'h40);
        $display("test inputs done");
        for (int k = 0; k < 4; k++) begin
            ppin <= 1'($random(seed));
            npin <= 1'($random(seed));
            d = 2'(k);
            wr_reg(`ACMP_ADDR_DIDR, 8'(d));
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk(8'({pbuf, nbuf, prd, nrd}), 8'({~d[0], ~d[1], ppin & ~d[0], npin & ~d[1]}));
        end
        wr_reg(`ACMP_ADDR_CSR, 8'h81);
        repeat (4) @(posedge clk);
        rd_reg(`ACMP_ADDR_CSR, 8'h81);
        chk(8'(pwr), 8'h00);
        $display("test pins and power done");
        repeat (3) @(posedge clk);
        finish_test();
    end
endmodule : acmp_ctrl_bench
